// [verilog/fsq_pkg.sv]
// Shared constants and types of the flow sampling sequencer.
// Assumes a single 100 MHz system clock and plain-port settings.
package fsq_pkg;

	// Two-digit program numbers, as entered before start
	localparam logic [7:0] PROG_WINDOW = 8'h01;
	localparam logic [7:0] PROG_OVERRIDE = 8'h02;
	localparam logic [7:0] PROG_EVENT = 8'h03;

	// Interval entry limits, hours and minutes
	localparam int INTV_W = 13;
	localparam logic [6:0] HOURS_MAX = 7'h63;
	localparam logic [5:0] MINS_MAX = 6'h3b;
	localparam logic [12:0] MINS_PER_HOUR = 13'h003c;
	localparam logic [12:0] INTV_MIN = 13'h0001;

	// Timebase: clock period, one minute, contact debounce time
	localparam longint unsigned CLK_PERIOD_NS = 64'h000000000000000a;
	localparam longint unsigned MINUTE_NS = 64'h0000000df8475800;
	localparam longint unsigned CYCLES_PER_MIN = MINUTE_NS / CLK_PERIOD_NS;
	localparam longint unsigned DEBOUNCE_NS = 64'h0000000000989680;
	localparam longint unsigned DEBOUNCE_CYCLES = DEBOUNCE_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 33;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_ADV = 3'b010,
		ST_DRAW = 3'b011,
		ST_DONE = 3'b100
	} fsq_state_t;

	// Running program
	typedef enum logic [1:0] {
		M_NONE = 2'b00,
		M_WINDOW = 2'b01,
		M_OVERRIDE = 2'b10,
		M_EVENT = 2'b11
	} fsq_mode_t;

endpackage : fsq_pkg

// [verilog/fsq_debounce.sv]
// Contact closure input conditioner: synchroniser, debounce, rise pulse.
// Assumes the raw contact may bounce for less than STABLE_CYCLES cycles.
`timescale 1ns/100ps
`default_nettype none
module fsq_debounce #(
	parameter int unsigned STABLE_CYCLES = 1000000
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Raw contact, closed high
	input wire logic raw_in,
	// Conditioned level and closing edge
	output logic level,
	output logic rise
);
	localparam int CNT_W = $clog2(STABLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

	logic sync1, sync2;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic next_level, next_rise;

	// Level accepted only after it stays put for the whole stable time
	always_comb begin
		next_cnt = '0;
		next_level = level;
		next_rise = 1'b0;
		if (sync2 != level) begin
			next_cnt = cnt + 1'b1;
			if (cnt == CNT_LAST) begin
				next_cnt = '0;
				next_level = sync2;
				next_rise = sync2;
			end
		end
	end

	// First stage feeds only the second, metastability guard
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			cnt <= '0;
			level <= 1'b0;
			rise <= 1'b0;
		end else if (clk_en) begin
			sync1 <= raw_in;
			sync2 <= sync1;
			cnt <= next_cnt;
			level <= next_level;
			rise <= next_rise;
		end
	end
endmodule : fsq_debounce
`default_nettype wire

// [verilog/fsq_sequencer.sv]
// Flow-triggered multi-bottle sampling sequencer: windowed, override, event.
// Assumes synchronous inputs, actuators that acknowledge with one-cycle pulses.
// What this block does
// - Program number 01, 02 or 03 picks window, override or event mode.
// - Each sequence advances the spout, then draws exactly one sample.
// - Intervals range from one minute to 99 hours 59 minutes.
// - Window mode: each bottle owns one window; samples go to it only.
// - Window mode: a closure samples into its window's bottle; one still pending at expiry goes to the next bottle, or is lost after the last.
// - Window mode: equal windows, next starts at once on expiry.
// - Window mode: window without closure ends with one sample there.
// - Window mode runs until every bottle holds at least one sample.
// - Window mode ignores the bottle full signal.
// - Override mode: countdown starts at program start, beside closure watch.
// - Override mode: each closure samples once and bumps the count.
// - Override mode: timeout without closure forces one sequence.
// - Override mode ends on all bottles filled or bottle full.
// - Event mode: the first closure samples at once.
// - Event mode: while held closed, sample each time the interval elapses.
// - Event mode: momentary closures sample once each; hold for intervals.
// - Event mode: contact opening suspends until a new closure.
// - Event mode: resume keeps bottle and sample position.
// - Event mode ends on all bottles filled or bottle full.
// - Deferred start is refused in event mode.
// - Bottle count comes from the bottle count setting.
`timescale 1ns/100ps
`default_nettype none
module fsq_sequencer #(
	parameter int BOTTLE_W = 7,
	parameter int SAMPLE_W = 8,
	parameter int TOTAL_W = 16,
	parameter longint unsigned MIN_CYCLES = fsq_pkg::CYCLES_PER_MIN,
	parameter int unsigned DEB_CYCLES = 32'(fsq_pkg::DEBOUNCE_CYCLES)
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Settings, sampled on start
	input wire logic start,
	input wire logic [7:0] prog_num,
	input wire logic [6:0] intv_hours,
	input wire logic [5:0] intv_mins,
	input wire logic [BOTTLE_W-1:0] bottle_count,
	input wire logic [SAMPLE_W-1:0] samples_per_bottle,
	input wire logic defer_req,
	// Field inputs
	input wire logic closure_in,
	input wire logic bottle_full,
	// Actuators
	output logic spout_adv,
	input wire logic spout_ack,
	output logic pump_draw,
	input wire logic pump_ack,
	// Status
	output logic running,
	output logic suspended,
	output logic prog_done,
	output logic prog_err,
	output logic defer_granted,
	output logic [BOTTLE_W-1:0] bottle_idx,
	output logic [SAMPLE_W-1:0] sample_in_bottle,
	output logic [TOTAL_W-1:0] sample_total
);
	localparam logic [fsq_pkg::TICK_W-1:0] TICK_LAST = fsq_pkg::TICK_W'(MIN_CYCLES - 1);
	localparam int IW = fsq_pkg::INTV_W;

	fsq_pkg::fsq_state_t state, next_state;
	fsq_pkg::fsq_mode_t mode, next_mode;
	logic [IW-1:0] interval, next_interval;
	logic [BOTTLE_W-1:0] last_bottle, next_last_bottle, next_bottle_idx;
	logic [SAMPLE_W-1:0] per_bottle, next_per_bottle, next_sample_in_bottle;
	logic [TOTAL_W-1:0] next_sample_total;
	logic exp_pend, next_exp_pend, clos_pend, next_clos_pend;
	logic win_has, next_win_has, exp_seq, next_exp_seq;
	logic next_prog_err, next_defer_granted;
	logic [fsq_pkg::TICK_W-1:0] tick, next_tick;
	logic [IW-1:0] min_left, next_min_left;
	logic clos_lvl, clos_rise, timer_run, tmr_restart, expire, last_sample;

	function automatic logic [IW-1:0] to_minutes(input logic [6:0] h, input logic [5:0] m);
		logic [6:0] hc;
		logic [5:0] mc;
		logic [IW-1:0] t;
		hc = (h > fsq_pkg::HOURS_MAX) ? fsq_pkg::HOURS_MAX : h;
		mc = (m > fsq_pkg::MINS_MAX) ? fsq_pkg::MINS_MAX : m;
		t = IW'(hc) * fsq_pkg::MINS_PER_HOUR + IW'(mc);
		return (t < fsq_pkg::INTV_MIN) ? fsq_pkg::INTV_MIN : t;
	endfunction : to_minutes

	fsq_debounce #(
		.STABLE_CYCLES(DEB_CYCLES)
	) u_deb (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.raw_in(closure_in),
		.level(clos_lvl),
		.rise(clos_rise)
	);

	assign last_sample = (sample_in_bottle == per_bottle - 1'b1) && (bottle_idx == last_bottle);

	// event mode counts only while the contact is held
	assign timer_run = running && (mode != fsq_pkg::M_EVENT || clos_lvl);
	assign expire = timer_run && tick == TICK_LAST && min_left == fsq_pkg::INTV_MIN;

	// Minute timebase; reloads itself on expiry so windows follow back to back
	always_comb begin
		next_tick = tick;
		next_min_left = min_left;
		if (tmr_restart || !timer_run) begin
			next_tick = '0;
			// New interval on the start edge, else the first count uses the old one
			next_min_left = next_interval;
		end else if (tick == TICK_LAST) begin
			next_tick = '0;
			next_min_left = expire ? interval : min_left - 1'b1;
		end else begin
			next_tick = tick + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tick <= '0;
			min_left <= fsq_pkg::INTV_MIN;
		end else if (clk_en) begin
			tick <= next_tick;
			min_left <= next_min_left;
		end
	end

	// Sequencer: program select, sampling sequence, bottle bookkeeping
	always_comb begin
		next_state = state;
		next_mode = mode;
		next_interval = interval;
		next_last_bottle = last_bottle;
		next_per_bottle = per_bottle;
		next_bottle_idx = bottle_idx;
		next_sample_in_bottle = sample_in_bottle;
		next_sample_total = sample_total;
		next_prog_err = prog_err;
		next_defer_granted = defer_granted;
		next_win_has = win_has;
		next_exp_seq = exp_seq;
		// Events latch, set wins over the clear below
		next_exp_pend = exp_pend;
		next_clos_pend = clos_pend;
		tmr_restart = 1'b0;
		unique case (state)
			fsq_pkg::ST_IDLE, fsq_pkg::ST_DONE: begin
				next_exp_pend = 1'b0;
				next_clos_pend = 1'b0;
				if (start) begin
					next_prog_err = 1'b0;
					next_interval = to_minutes(intv_hours, intv_mins);
					// bottles from the bottle count setting
					next_last_bottle = (bottle_count == '0) ? '0 : bottle_count - 1'b1;
					next_per_bottle = (samples_per_bottle == '0) ? SAMPLE_W'(1) : samples_per_bottle;
					next_bottle_idx = '0;
					next_sample_in_bottle = '0;
					next_sample_total = '0;
					next_win_has = 1'b0;
					next_exp_seq = 1'b0;
					tmr_restart = 1'b1;
					next_state = fsq_pkg::ST_WAIT;
					unique case (prog_num)
						fsq_pkg::PROG_WINDOW: next_mode = fsq_pkg::M_WINDOW;
						fsq_pkg::PROG_OVERRIDE: next_mode = fsq_pkg::M_OVERRIDE;
						fsq_pkg::PROG_EVENT: next_mode = fsq_pkg::M_EVENT;
						default: begin
							next_mode = fsq_pkg::M_NONE;
							next_prog_err = 1'b1;
							next_state = state;
						end
					endcase
					// no deferred start in event mode
					next_defer_granted = defer_req && !next_prog_err && prog_num != fsq_pkg::PROG_EVENT;
				end
			end
			fsq_pkg::ST_WAIT: begin
				if (mode == fsq_pkg::M_WINDOW) begin
					// bottle full is not watched here
					if (exp_pend) begin
						if (!win_has) begin
							// empty window still gets one sample
							next_exp_seq = 1'b1;
							next_state = fsq_pkg::ST_ADV;
						end else begin
							next_exp_pend = 1'b0;
							next_win_has = 1'b0;
							// stop once the last window has a sample
							if (bottle_idx == last_bottle) begin
								next_state = fsq_pkg::ST_DONE;
							end else begin
								next_bottle_idx = bottle_idx + 1'b1;
							end
						end
					end else if (clos_pend) begin
						// closure samples into the active bottle
						next_clos_pend = 1'b0;
						next_state = fsq_pkg::ST_ADV;
					end
				end else if (bottle_full) begin
					// same end condition in event mode
					next_state = fsq_pkg::ST_DONE;
				end else if (clos_pend) begin
					next_clos_pend = 1'b0;
					next_exp_pend = 1'b0;
					next_state = fsq_pkg::ST_ADV;
				end else if (exp_pend) begin
					next_exp_pend = 1'b0;
					next_state = fsq_pkg::ST_ADV;
				end
			end
			fsq_pkg::ST_ADV: begin
				if (spout_ack) begin
					next_state = fsq_pkg::ST_DRAW;
				end
			end
			fsq_pkg::ST_DRAW: begin
				if (pump_ack) begin
					next_sample_total = sample_total + 1'b1;
					next_state = fsq_pkg::ST_WAIT;
					if (mode == fsq_pkg::M_WINDOW) begin
						// bottle only changes at window end
						next_win_has = 1'b1;
						if (exp_seq) begin
							next_exp_seq = 1'b0;
							next_exp_pend = 1'b0;
							next_win_has = 1'b0;
							if (bottle_idx == last_bottle) begin
								next_state = fsq_pkg::ST_DONE;
							end else begin
								next_bottle_idx = bottle_idx + 1'b1;
							end
						end
					end else begin
						tmr_restart = 1'b1;
						next_exp_pend = 1'b0;
						if (last_sample) begin
							next_state = fsq_pkg::ST_DONE;
						end else if (sample_in_bottle == per_bottle - 1'b1) begin
							next_sample_in_bottle = '0;
							next_bottle_idx = bottle_idx + 1'b1;
						end else begin
							next_sample_in_bottle = sample_in_bottle + 1'b1;
						end
					end
				end
			end
			default: next_state = fsq_pkg::ST_IDLE;
		endcase
		// Events seen during a sequence wait their turn
		if (running && clos_rise) begin
			next_clos_pend = 1'b1;
		end
		if (expire) begin
			next_exp_pend = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= fsq_pkg::ST_IDLE;
			mode <= fsq_pkg::M_NONE;
			interval <= fsq_pkg::INTV_MIN;
			last_bottle <= '0;
			per_bottle <= '0;
			bottle_idx <= '0;
			sample_in_bottle <= '0;
			sample_total <= '0;
			prog_err <= 1'b0;
			defer_granted <= 1'b0;
			win_has <= 1'b0;
			exp_seq <= 1'b0;
			exp_pend <= 1'b0;
			clos_pend <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			mode <= next_mode;
			interval <= next_interval;
			last_bottle <= next_last_bottle;
			per_bottle <= next_per_bottle;
			bottle_idx <= next_bottle_idx;
			sample_in_bottle <= next_sample_in_bottle;
			sample_total <= next_sample_total;
			prog_err <= next_prog_err;
			defer_granted <= next_defer_granted;
			win_has <= next_win_has;
			exp_seq <= next_exp_seq;
			exp_pend <= next_exp_pend;
			clos_pend <= next_clos_pend;
		end
	end

	// Status decode; requests stand until acknowledged
	assign running = state inside {fsq_pkg::ST_WAIT, fsq_pkg::ST_ADV, fsq_pkg::ST_DRAW};
	assign spout_adv = state == fsq_pkg::ST_ADV;
	assign pump_draw = state == fsq_pkg::ST_DRAW;
	assign prog_done = state == fsq_pkg::ST_DONE;
	assign suspended = running && mode == fsq_pkg::M_EVENT && !clos_lvl;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence spout_taken;
		spout_adv && spout_ack && clk_en;
	endsequence
	sequence draw_follows;
		##1 pump_draw && $stable(bottle_idx);
	endsequence

	mode_select_a: assert property (state == fsq_pkg::ST_IDLE && start && clk_en && prog_num == fsq_pkg::PROG_EVENT |=> mode == fsq_pkg::M_EVENT && running) else $error("event program not selected");
	seq_order_a: assert property (spout_taken |-> draw_follows) else $error("draw did not follow spout advance");
	intv_range_a: assert property (running |-> interval >= fsq_pkg::INTV_MIN && interval <= 13'h176f) else $error("interval out of range");
	window_hold_a: assert property (mode == fsq_pkg::M_WINDOW && pump_draw |=> $stable(bottle_idx) || $past(exp_seq)) else $error("window bottle moved during sample");
	window_nofull_a: assert property (mode == fsq_pkg::M_WINDOW && state == fsq_pkg::ST_WAIT && bottle_full && !exp_pend |=> !prog_done) else $error("window mode stopped on bottle full");
	sample_count_a: assert property (pump_draw && pump_ack && clk_en |=> sample_total == $past(sample_total) + 1'b1) else $error("sample count not bumped");
	ovr_full_a: assert property (mode == fsq_pkg::M_OVERRIDE && state == fsq_pkg::ST_WAIT && bottle_full && clk_en |=> prog_done) else $error("override mode ignored bottle full");
	event_suspend_a: assert property (suspended |-> !timer_run ##1 (min_left == interval || !clk_en)) else $error("timer ran with contact open");
	defer_block_a: assert property (defer_granted |-> mode != fsq_pkg::M_EVENT) else $error("deferred start granted in event mode");
	ovr_restart_a: assert property (mode == fsq_pkg::M_OVERRIDE && pump_draw && pump_ack && clk_en |=> tick == '0 && min_left == interval) else $error("override timer not restarted");
endmodule : fsq_sequencer
`default_nettype wire

// [sim/fsq_relay_model.sv]
// Far-side model: field relay contact plus spout and pump actuators.
// Assumes the bench drives contact_cmd and ack_dly by NBA on falling edges.
`timescale 1ns/100ps
`default_nettype none
module fsq_relay_model (
	// Clock
	input wire logic ref_clk,
	// Bench commands
	input wire logic contact_cmd,
	input wire logic [2:0] ack_dly,
	// Contact to sampler, high = closed
	output logic closure_in,
	// Actuator handshake
	input wire logic spout_adv,
	output logic spout_ack,
	input wire logic pump_draw,
	output logic pump_ack
);
	logic cmd_q = 1'b0;
	logic [1:0] bnc = 2'h0;
	logic [2:0] s_cnt = 3'h0;
	logic [2:0] p_cnt = 3'h0;

	// held or momentary contact
	// Closing edge chatters three cycles, shorter than the debounce time
	always @(negedge ref_clk) begin
		cmd_q <= contact_cmd;
		if (contact_cmd && !cmd_q)
			bnc <= 2'h3;
		else if (bnc != 2'h0)
			bnc <= bnc - 2'h1;
	end
	assign closure_in = contact_cmd & ((bnc == 2'h0) | bnc[0]);

	// One-cycle acks after a variable delay, so slow actuators are seen too
	always @(negedge ref_clk) begin
		spout_ack <= 1'b0;
		pump_ack <= 1'b0;
		s_cnt <= (spout_adv === 1'b1) ? s_cnt + 3'h1 : 3'h0;
		p_cnt <= (pump_draw === 1'b1) ? p_cnt + 3'h1 : 3'h0;
		if (spout_adv === 1'b1 && !spout_ack && s_cnt >= ack_dly) begin
			spout_ack <= 1'b1;
			s_cnt <= 3'h0;
		end
		if (pump_draw === 1'b1 && !pump_ack && p_cnt >= ack_dly) begin
			pump_ack <= 1'b1;
			p_cnt <= 3'h0;
		end
	end
endmodule : fsq_relay_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the sampling sequencer in all three programs.
// Assumes short timebase parameters: 100 cycles a minute, 4-cycle debounce.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic start = 1'b0;
	logic [7:0] prog_num = 8'h00;
	logic [6:0] intv_hours = 7'h00;
	logic [5:0] intv_mins = 6'h00;
	logic [6:0] bottle_count = 7'h00;
	logic [7:0] samples_per_bottle = 8'h00;
	logic defer_req = 1'b0;
	logic contact_cmd = 1'b0;
	logic bottle_full = 1'b0;
	logic [2:0] ack_dly = 3'h0;
	logic clk_en = 1'b1;
	logic closure_in, spout_adv, spout_ack, pump_draw, pump_ack;
	logic running, suspended, prog_done, prog_err, defer_granted;
	logic [6:0] bottle_idx;
	logic [6:0] b_at;
	logic [7:0] sample_in_bottle;
	logic [15:0] sample_total;
	int err_count = 0;
	int n_checks = 0;
	int n_samp = 0;
	int n_all = 0;
	int adv_cnt = 0;
	int cyc = 0;
	int last_cyc = 0;
	int last_gap = 0;
	int t0 = 0;
	int seed = 61949;
	int exp_q[$];
	int b_exp = 0;
	int k_exp = 0;

	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	fsq_sequencer #(.MIN_CYCLES(100), .DEB_CYCLES(4)) u_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .start(start),
		.prog_num(prog_num), .intv_hours(intv_hours), .intv_mins(intv_mins),
		.bottle_count(bottle_count), .samples_per_bottle(samples_per_bottle),
		.defer_req(defer_req), .closure_in(closure_in), .bottle_full(bottle_full),
		.spout_adv(spout_adv), .spout_ack(spout_ack), .pump_draw(pump_draw),
		.pump_ack(pump_ack), .running(running), .suspended(suspended),
		.prog_done(prog_done), .prog_err(prog_err), .defer_granted(defer_granted),
		.bottle_idx(bottle_idx), .sample_in_bottle(sample_in_bottle),
		.sample_total(sample_total));

	fsq_relay_model u_relay (
		.ref_clk(ref_clk), .contact_cmd(contact_cmd), .ack_dly(ack_dly),
		.closure_in(closure_in), .spout_adv(spout_adv), .spout_ack(spout_ack),
		.pump_draw(pump_draw), .pump_ack(pump_ack));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task test_done;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	task cycles(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cycles

	// Settings only matter on the start edge; minutes only, hours stay zero
	task run(input logic [7:0] p, input logic [5:0] m, input logic [6:0] b,
			input logic [7:0] s, input logic d);
		@(negedge ref_clk);
		prog_num = p;
		intv_mins = m;
		bottle_count = b;
		samples_per_bottle = s;
		defer_req = d;
		start = 1'b1;
		n_samp = 0;
		@(negedge ref_clk);
		start = 1'b0;
		t0 = cyc;
		last_cyc = cyc;
	endtask : run

	// Momentary closure, long enough to pass the debounce
	task pulse;
		contact_cmd <= 1'b1;
		cycles(12);
		contact_cmd <= 1'b0;
		cycles(12);
	endtask : pulse

	task wait_samples(input int k, input int lim);
		int i;
		for (i = 0; i < lim && n_samp < k; i++)
			@(negedge ref_clk);
		check(32'(n_samp >= k), 32'h1);
	endtask : wait_samples

	task wait_done(input int lim);
		int i;
		for (i = 0; i < lim && prog_done !== 1'b1; i++)
			@(negedge ref_clk);
		check(prog_done, 32'h1);
	endtask : wait_done

	// Cycle count and accepted spout advances
	always @(negedge ref_clk) cyc++;
	always @(posedge ref_clk)
		if (spout_adv === 1'b1 && spout_ack === 1'b1)
			adv_cnt++;

	// Reference model: every finished draw against count, bottle and order
	// Expectations taken at the draw edge, before the next scenario reloads them
	initial forever begin
		@(posedge ref_clk);
		if (pump_draw === 1'b1 && pump_ack === 1'b1) begin
			b_at = bottle_idx;
			n_samp++;
			n_all++;
			k_exp = n_samp;
			b_exp = exp_q.size() > 0 ? exp_q.pop_front() : 32'hff;
			last_gap = cyc - last_cyc;
			last_cyc = cyc;
			@(negedge ref_clk);
			ack_dly <= 3'($random(seed));
			check(sample_total, k_exp);
			check(b_at, b_exp);
			check(adv_cnt, n_all);
		end
	end

	// Watchdog well beyond the longest expected run
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		test_done();
	end

	initial begin
		cycles(12);
		sys_rst = 1'b0;
		cycles(2);
		check(running, 32'h0);
		// Unknown program number is refused
		run(8'h04, 6'h01, 7'h02, 8'h02, 1'b0);
		cycles(2);
		check({prog_err, running}, 32'h2);
		// Override, two minutes: closure, then timeouts
		exp_q = '{0, 0, 1, 1};
		run(8'h02, 6'h02, 7'h02, 8'h02, 1'b1);
		check({running, defer_granted}, 32'h3);
		cycles(10);
		pulse();
		wait_samples(1, 60);
		check(32'(last_cyc - t0 < 95), 32'h1);
		wait_samples(2, 250);
		check(32'(last_gap >= 200 && last_gap <= 230), 32'h1);
		wait_samples(3, 250);
		check(32'(last_gap >= 200 && last_gap <= 230), 32'h1);
		wait_done(250);
		check(sample_total, 32'h4);
		// Override: zero minutes counts as one; 20 frozen cycles stretch the timeout
		exp_q = '{0};
		run(8'h02, 6'h00, 7'h02, 8'h02, 1'b0);
		cycles(20);
		clk_en = 1'b0;
		cycles(20);
		clk_en = 1'b1;
		wait_samples(1, 170);
		check(32'(last_gap >= 115 && last_gap <= 150), 32'h1);
		bottle_full = 1'b1;
		wait_done(5);
		check(sample_total, 32'h1);
		// Window: two closures in window one, empty windows force a draw
		exp_q = '{0, 0, 1, 2};
		run(8'h01, 6'h01, 7'h03, 8'h01, 1'b0);
		cycles(4);
		pulse();
		pulse();
		wait_done(400);
		check(sample_total, 32'h4);
		check(32'(last_cyc - t0 >= 295), 32'h1);
		check(n_samp, 32'h4);
		bottle_full = 1'b0;
		// Event: momentary, then held, then suspended, then resumed
		exp_q = '{0, 0, 0, 0};
		run(8'h03, 6'h01, 7'h01, 8'h04, 1'b1);
		check(defer_granted, 32'h0);
		pulse();
		wait_samples(1, 40);
		cycles(150);
		check({suspended, 8'(n_samp)}, 32'h101);
		contact_cmd <= 1'b1;
		t0 = cyc;
		wait_samples(2, 40);
		check(32'(last_cyc - t0 <= 35), 32'h1);
		wait_samples(3, 150);
		check(32'(last_gap >= 100 && last_gap <= 130), 32'h1);
		contact_cmd <= 1'b0;
		cycles(150);
		check({suspended, sample_in_bottle}, 32'h103);
		contact_cmd <= 1'b1;
		wait_samples(4, 40);
		wait_done(10);
		contact_cmd <= 1'b0;
		// Let the reference model finish its last compare
		cycles(2);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
